/* verilog/hsm_consts.svh */
// Constants for the power and energy monitor datapath.
// Assumes inclusion by bare name from design files only.
`ifndef HSM_CONSTS_SVH
`define HSM_CONSTS_SVH

// Clock and timebase
`define REF_PERIOD_NS      20
`define TICK_NS            4000
`define INT_TICK_CYCLES    (`TICK_NS / `REF_PERIOD_NS)
`define EXT_IDLE_CYCLES    256
`define CUR_SAMPLE_NS      16000
`define CUR_SAMPLE_TICKS   (`CUR_SAMPLE_NS / `TICK_NS)
`define CONV12_NS          65535000
`define CONV16_NS          1048600000
`define CONV12_TICKS       (`CONV12_NS / `TICK_NS)
`define CONV16_TICKS       (`CONV16_NS / `TICK_NS)

// Register offsets
`define REG_SUPPLY_RANGE   8'h01
`define REG_ALERT_MASK     8'h03
`define REG_ALERT_LOG      8'h05
`define REG_THR_BASE       8'h08
`define REG_CLK_DIV        8'h10
`define REG_ADJUST         8'h11
`define REG_METER_CTL      8'h1D
`define REG_STATUS         8'h1F
`define REG_RESULT_BASE    8'h40
`define REG_ENERGY_BASE    8'h58
`define REG_COUNT_BASE     8'h5E

// Field positions
`define ADJ_RES16_BIT      0
`define ADJ_THIRD_GENERAL_INPUT_BIT      1
`define ADJ_VOUT_BIT       2
`define DIV_CHARGE_BIT     7
`define MCTL_RESET_BIT     6
`define MCTL_TICK_EN_BIT   0
`define MCTL_METER_EN_BIT  1

// Reset values
`define RST_BYTE           8'h00
`define RST_THR_MAX        8'hFF

`endif

/* verilog/hsm_pkg.sv */
// Types shared by the monitor datapath files.
// Assumes constants come from the header.
package hsm_pkg;

	// Left-justified converter results
	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] volt;
		logic [15:0] gpio;
	} meas_t;

	// Register port states
	typedef enum logic [6:0] {
		S_IDLE  = 7'b0000001,
		S_ADDR  = 7'b0000010,
		S_ACK_A = 7'b0000100,
		S_WR    = 7'b0001000,
		S_ACK_W = 7'b0010000,
		S_RD    = 7'b0100000,
		S_ACK_R = 7'b1000000
	} link_state_t;

endpackage : hsm_pkg

/* verilog/extreme_tracker.sv */
// Running minimum and maximum of one word.
// Assumes update is a one-cycle strobe on the same clock.
`timescale 1ns/1ps
`default_nettype none

module extreme_tracker #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// New value
	input  wire logic         update,
	input  wire logic [W-1:0] value,
	// Stored extremes
	output logic      [W-1:0] min_val,
	output logic      [W-1:0] max_val
);

	if (W < 1) begin : g_chk
		$error("extreme_tracker: W must be positive");
	end

	// Replace an extreme the new value passes
	always_ff @(posedge clk) begin
		if (rst) begin
			min_val <= '1;
			max_val <= '0;
		end else if (update) begin
			if (value < min_val) min_val <= value;
			if (value > max_val) max_val <= value;
		end
	end

endmodule : extreme_tracker
`default_nettype wire

/* verilog/timebase_gen.sv */
// Makes the 250 kHz tick from the internal or an external clock.
// Assumes ext_level is synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
`include "hsm_consts.svh"

module timebase_gen (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// External timebase
	input  wire logic       ext_level,
	input  wire logic [4:0] div_code,
	// Tick out
	output logic            tick,
	output logic            ext_present
);

	logic        ext_prev;
	logic [8:0]  idle_cnt;
	logic [7:0]  int_cnt;
	logic [5:0]  ext_cnt;
	logic        ext_rise;

	assign ext_rise = ext_level & ~ext_prev;

	// Edge history and idle detection; a grounded input never toggles
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_prev    <= 1'b0;
			idle_cnt    <= 9'(`EXT_IDLE_CYCLES);
			ext_present <= 1'b0;
		end else begin
			ext_prev <= ext_level;
			if (ext_rise) idle_cnt <= 9'h000;
			else if (idle_cnt != 9'(`EXT_IDLE_CYCLES)) idle_cnt <= idle_cnt + 9'h001;
			ext_present <= (idle_cnt != 9'(`EXT_IDLE_CYCLES));
		end
	end

	// Tick from internal or divided external clock
	always_ff @(posedge clk) begin
		if (rst) begin
			int_cnt <= 8'h00;
			ext_cnt <= 6'h00;
			tick    <= 1'b0;
		end else if (ext_present) begin
			int_cnt <= 8'h00;
			tick    <= 1'b0;
			if (ext_rise) begin
				if (div_code == 5'h00) begin
					tick <= 1'b1;
				end else if (ext_cnt >= {div_code, 1'b0} - 6'h01) begin
					ext_cnt <= 6'h00;
					tick    <= 1'b1;
				end else begin
					ext_cnt <= ext_cnt + 6'h01;
				end
			end
		end else begin
			ext_cnt <= 6'h00;
			if (int_cnt == 8'(`INT_TICK_CYCLES - 1)) begin
				int_cnt <= 8'h00;
				tick    <= 1'b1;
			end else begin
				int_cnt <= int_cnt + 8'h01;
				tick    <= 1'b0;
			end
		end
	end

endmodule : timebase_gen
`default_nettype wire

/* verilog/power_energy_monitor_datapath.sv */
// Monitor datapath: timing, power, extremes, alarms, energy meter,
// and the register port.
// Assumes front end on REF_CLK; SCL, SDA, clock pin asynchronous.
//
// Overview of operation
// - Adjust bit 0 picks 12 or 16 bits
// - Adjust bit 2 picks input or output voltage
// - Adjust bit 1 picks second or third input
// - Full scale ranges set; supply range selectable
// - Lockstep converters; power equals current times voltage
// - Track min and max of every result
// - Threshold crossings set log, alert when masked
// - Add power into 48-bit energy accumulator
// - Current sampled every 16 microseconds
// - Optional alert on energy accumulator overflow
// - Divider bit 7 selects charge metering
// - 32-bit counter increments per accumulation
// - Counter alert at full scale before rollover
// - Software may preload accumulator and counter
// - 12-bit results left-justified in word
// - Conversion period 0.065535s or 1.0486s
// - Byte thresholds; falling trips one step higher
// - Grounded clock input selects internal oscillator
// - External clock divided by twice code, or undivided at code 0
// - Overflow flags clear only via meter reset
`timescale 1ns/1ps
`default_nettype none
`include "hsm_consts.svh"

module power_energy_monitor_datapath #(
	parameter logic [6:0] DEV_ADDR     = 7'h50,
	parameter int         CONV12_TICKS = `CONV12_TICKS,
	parameter int         CONV16_TICKS = `CONV16_TICKS
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	// Timebase pins
	input  wire logic        EXT_CLK_IN,
	output logic             CRYSTAL_DRIVE,
	// Two-wire register port
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE_N,
	// Alert pin, open drain
	output logic             ALERT_OUT,
	output logic             ALERT_OE_N,
	// Converter front end control
	output logic             CONV_START,
	output logic             CUR_SAMPLE,
	output logic             CONV_RES16,
	output logic [1:0]       VOLT_RANGE,
	// Converter front end results
	input  wire logic        ADC_READY,
	input  wire logic [15:0] ADC_CUR_CODE,
	input  wire logic [15:0] ADC_VIN_CODE,
	input  wire logic [15:0] ADC_VOUT_CODE,
	input  wire logic [15:0] ADC_SECOND_GENERAL_INPUT_CODE,
	input  wire logic [15:0] ADC_THIRD_GENERAL_INPUT_CODE
);

	if (CONV12_TICKS < 1 || CONV16_TICKS < 1 || CONV16_TICKS > 2**20 - 1) begin : g_chk
		$error("power_energy_monitor_datapath: conversion tick counts out of range");
	end

	// Synchronisers
	logic [1:0] ext_sync, scl_sync, sda_sync;
	logic       scl_prev, sda_prev;
	// Registers
	logic [7:0] supply_range, alert_mask, alert_log, clk_div, adjust, meter_ctl;
	logic [7:0] thr [8];
	logic       meter_ovf, tick_ovf, reset_prev;
	logic [47:0] energy;
	logic [31:0] conv_count;
	// Datapath
	hsm_pkg::meas_t meas;
	logic        meas_valid;
	logic [31:0] product;
	logic [15:0] power_word;
	logic [47:0] add_val;
	logic [48:0] acc_sum;
	logic [7:0]  next_log_set;
	logic [15:0] pmin, pmax, cmin, cmax, vmin, vmax, gmin, gmax;
	// Timing
	logic        tick, ext_present;
	logic [19:0] conv_cnt;
	logic [2:0]  samp_cnt;
	// Register port
	hsm_pkg::link_state_t state;
	logic [7:0]  shift, pointer, rd_byte;
	logic [3:0]  bit_cnt;
	logic        rw, first_byte, wr_en;
	logic [7:0]  wr_addr, wr_data;
	logic        scl_rise, scl_fall, start_c, stop_c;
	logic        meter_rst, acc_en;
	logic [7:0]  e_idx, c_idx;

	// Two flip-flops on every asynchronous pin
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ext_sync <= 2'b00;
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			ext_sync <= {ext_sync[0], EXT_CLK_IN};
			scl_sync <= {scl_sync[0], SCL_IN};
			sda_sync <= {sda_sync[0], SDA_IN};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] & ~scl_prev;
	assign scl_fall = ~scl_sync[1] & scl_prev;
	assign start_c  = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
	assign stop_c   = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

	// Timebase source and divider
	timebase_gen u_timebase (
		.clk         (REF_CLK),
		.rst         (RST),
		.ext_level   (ext_sync[1]),
		.div_code    (clk_div[4:0]),
		.tick        (tick),
		.ext_present (ext_present)
	);

	// Conversion and current sample strobes
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			conv_cnt   <= 20'h00000;
			samp_cnt   <= 3'h0;
			CONV_START <= 1'b0;
			CUR_SAMPLE <= 1'b0;
		end else begin
			CONV_START <= 1'b0;
			CUR_SAMPLE <= 1'b0;
			if (tick) begin
				if (samp_cnt == 3'(`CUR_SAMPLE_TICKS - 1)) begin
					samp_cnt   <= 3'h0;
					CUR_SAMPLE <= 1'b1;
				end else begin
					samp_cnt <= samp_cnt + 3'h1;
				end
				if (conv_cnt >= (adjust[`ADJ_RES16_BIT] ? 20'(CONV16_TICKS - 1)
						: 20'(CONV12_TICKS - 1))) begin
					conv_cnt   <= 20'h00000;
					CONV_START <= 1'b1;
				end else begin
					conv_cnt <= conv_cnt + 20'h00001;
				end
			end
		end
	end

	// Front end configuration and crystal drive
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			CONV_RES16    <= 1'b0;
			VOLT_RANGE    <= 2'b00;
			CRYSTAL_DRIVE <= 1'b0;
		end else begin
			CONV_RES16    <= adjust[`ADJ_RES16_BIT];
			VOLT_RANGE    <= supply_range[1:0];
			CRYSTAL_DRIVE <= ext_present & ~ext_sync[1];
		end
	end

	// Capture results, select channels, left-justify
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			meas       <= '0;
			meas_valid <= 1'b0;
		end else begin
			meas_valid <= ADC_READY;
			if (ADC_READY) begin
				if (adjust[`ADJ_RES16_BIT]) begin
					meas.cur  <= ADC_CUR_CODE;
					meas.volt <= adjust[`ADJ_VOUT_BIT] ? ADC_VOUT_CODE : ADC_VIN_CODE;
					meas.gpio <= adjust[`ADJ_THIRD_GENERAL_INPUT_BIT] ? ADC_THIRD_GENERAL_INPUT_CODE : ADC_SECOND_GENERAL_INPUT_CODE;
				end else begin
					meas.cur  <= {ADC_CUR_CODE[11:0], 4'h0};
					meas.volt <= adjust[`ADJ_VOUT_BIT] ? {ADC_VOUT_CODE[11:0], 4'h0}
						: {ADC_VIN_CODE[11:0], 4'h0};
					meas.gpio <= adjust[`ADJ_THIRD_GENERAL_INPUT_BIT] ? {ADC_THIRD_GENERAL_INPUT_CODE[11:0], 4'h0}
						: {ADC_SECOND_GENERAL_INPUT_CODE[11:0], 4'h0};
				end
			end
		end
	end

	// Power product and meter increment
	assign product    = meas.cur * meas.volt;
	assign power_word = product[31:16];
	assign add_val    = clk_div[`DIV_CHARGE_BIT] ? {32'h00000000, meas.cur}
		: {24'h000000, product[31:8]};
	assign acc_sum    = {1'b0, energy} + {1'b0, add_val};
	assign acc_en     = meas_valid & ~meter_rst;
	assign meter_rst  = meter_ctl[`MCTL_RESET_BIT];
	assign e_idx      = wr_addr - `REG_ENERGY_BASE;
	assign c_idx      = wr_addr - `REG_COUNT_BASE;

	// Alarm crossings; falling trips at top edge of code
	always_comb begin
		next_log_set    = 8'h00;
		next_log_set[7] = power_word[15:8] >= thr[0];
		next_log_set[6] = power_word[15:8] <= thr[1];
		next_log_set[5] = meas.cur[15:8] >= thr[2];
		next_log_set[4] = meas.cur[15:8] <= thr[3];
		next_log_set[3] = meas.volt[15:8] >= thr[4];
		next_log_set[2] = meas.volt[15:8] <= thr[5];
		next_log_set[1] = meas.gpio[15:8] >= thr[6];
		next_log_set[0] = meas.gpio[15:8] <= thr[7];
	end

	// Extremes of every result
	extreme_tracker #(.W(16)) u_pwr (.clk(REF_CLK), .rst(RST), .update(meas_valid),
		.value(power_word), .min_val(pmin), .max_val(pmax));
	extreme_tracker #(.W(16)) u_cur (.clk(REF_CLK), .rst(RST), .update(meas_valid),
		.value(meas.cur), .min_val(cmin), .max_val(cmax));
	extreme_tracker #(.W(16)) u_vlt (.clk(REF_CLK), .rst(RST), .update(meas_valid),
		.value(meas.volt), .min_val(vmin), .max_val(vmax));
	extreme_tracker #(.W(16)) u_gpi (.clk(REF_CLK), .rst(RST), .update(meas_valid),
		.value(meas.gpio), .min_val(gmin), .max_val(gmax));

	// Energy accumulator: reset hold, preload, wrap
	always_ff @(posedge REF_CLK) begin
		if (RST || meter_rst) begin
			energy <= 48'h000000000000;
		end else if (wr_en && wr_addr >= `REG_ENERGY_BASE && wr_addr < `REG_COUNT_BASE) begin
			energy[8*(5 - 32'(e_idx[2:0])) +: 8] <= wr_data;
		end else if (acc_en) begin
			energy <= acc_sum[47:0];
		end
	end

	// Counter: one count per accumulation
	always_ff @(posedge REF_CLK) begin
		if (RST || meter_rst) begin
			conv_count <= 32'h00000000;
		end else if (wr_en && wr_addr >= `REG_COUNT_BASE && c_idx < 8'h04) begin
			conv_count[8*(3 - 32'(c_idx[1:0])) +: 8] <= wr_data;
		end else if (acc_en) begin
			conv_count <= conv_count + 32'h00000001;
		end
	end

	// Overflow flags: set wins, cleared on release of meter reset
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			meter_ovf  <= 1'b0;
			tick_ovf   <= 1'b0;
			reset_prev <= 1'b0;
		end else begin
			reset_prev <= meter_rst;
			if (acc_en && acc_sum[48]) meter_ovf <= 1'b1;
			else if (reset_prev && !meter_rst) meter_ovf <= 1'b0;
			if (acc_en && conv_count >= 32'hFFFFFFFE) tick_ovf <= 1'b1;
			else if (reset_prev && !meter_rst) tick_ovf <= 1'b0;
		end
	end

	// Alert log: host writes, crossings set and win
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			alert_log <= `RST_BYTE;
		end else begin
			alert_log <= ((wr_en && wr_addr == `REG_ALERT_LOG) ? wr_data : alert_log)
				| (meas_valid ? next_log_set : 8'h00);
		end
	end

	// Alert pin pulls low while any enabled event is logged
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ALERT_OUT  <= 1'b0;
			ALERT_OE_N <= 1'b1;
		end else begin
			ALERT_OUT  <= 1'b0;
			ALERT_OE_N <= ~(|(alert_log & alert_mask)
				| (meter_ovf & meter_ctl[`MCTL_METER_EN_BIT])
				| (tick_ovf & meter_ctl[`MCTL_TICK_EN_BIT]));
		end
	end

	// Host configuration registers
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			supply_range <= `RST_BYTE;
			alert_mask   <= `RST_BYTE;
			clk_div      <= `RST_BYTE;
			adjust       <= `RST_BYTE;
			meter_ctl    <= `RST_BYTE;
			for (int i = 0; i < 8; i++) thr[i] <= i[0] ? `RST_BYTE : `RST_THR_MAX;
		end else if (wr_en) begin
			case (wr_addr)
				`REG_SUPPLY_RANGE: supply_range <= wr_data;
				`REG_ALERT_MASK:   alert_mask   <= wr_data;
				`REG_CLK_DIV:      clk_div      <= wr_data;
				`REG_ADJUST:       adjust       <= wr_data;
				`REG_METER_CTL:    meter_ctl    <= wr_data;
				default: begin
					if (wr_addr[7:3] == 5'(`REG_THR_BASE >> 3)) thr[wr_addr[2:0]] <= wr_data;
				end
			endcase
		end
	end

	// Read data at the pointer
	always_comb begin
		rd_byte = 8'h00;
		case (pointer)
			`REG_SUPPLY_RANGE: rd_byte = supply_range;
			`REG_ALERT_MASK:   rd_byte = alert_mask;
			`REG_ALERT_LOG:    rd_byte = alert_log;
			`REG_CLK_DIV:      rd_byte = clk_div;
			`REG_ADJUST:       rd_byte = adjust;
			`REG_METER_CTL:    rd_byte = meter_ctl;
			`REG_STATUS:       rd_byte = {6'h00, meter_ovf, tick_ovf};
			default: begin
				if (pointer[7:3] == 5'(`REG_THR_BASE >> 3)) rd_byte = thr[pointer[2:0]];
				else if (pointer >= `REG_RESULT_BASE && pointer < `REG_ENERGY_BASE)
					rd_byte = result_byte(pointer - `REG_RESULT_BASE);
				else if (pointer >= `REG_ENERGY_BASE && pointer < `REG_COUNT_BASE)
					rd_byte = energy[8*(5 - 32'(pointer - `REG_ENERGY_BASE)) +: 8];
				else if (pointer >= `REG_COUNT_BASE && pointer < `REG_COUNT_BASE + 8'h04)
					rd_byte = conv_count[8*(3 - 32'(pointer - `REG_COUNT_BASE)) +: 8];
			end
		endcase
	end

	// Result, max, min words, high byte first
	function automatic logic [7:0] result_byte(input logic [7:0] idx);
		logic [16*12-1:0] words;
		words = {power_word, pmax, pmin, meas.cur, cmax, cmin,
			meas.volt, vmax, vmin, meas.gpio, gmax, gmin};
		result_byte = words[16*12 - 8 - 8*32'(idx[4:0]) +: 8];
	endfunction : result_byte

	// Two-wire slave: address, pointer, data
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state      <= hsm_pkg::S_IDLE;
			shift      <= 8'h00;
			pointer    <= 8'h00;
			bit_cnt    <= 4'h0;
			rw         <= 1'b0;
			first_byte <= 1'b0;
			wr_en      <= 1'b0;
			wr_addr    <= 8'h00;
			wr_data    <= 8'h00;
			SDA_OUT    <= 1'b0;
			SDA_OE_N   <= 1'b1;
		end else begin
			wr_en <= 1'b0;
			if (start_c) begin
				state    <= hsm_pkg::S_ADDR;
				bit_cnt  <= 4'h0;
				SDA_OE_N <= 1'b1;
			end else if (stop_c) begin
				state    <= hsm_pkg::S_IDLE;
				SDA_OE_N <= 1'b1;
			end else begin
				case (state)
					hsm_pkg::S_IDLE: ;
					hsm_pkg::S_ADDR, hsm_pkg::S_WR: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda_sync[1]};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							if (state == hsm_pkg::S_ADDR) begin
								if (shift[7:1] == DEV_ADDR) begin
									rw       <= shift[0];
									SDA_OE_N <= 1'b0;
									state    <= hsm_pkg::S_ACK_A;
								end else begin
									state <= hsm_pkg::S_IDLE;
								end
							end else begin
								SDA_OE_N <= 1'b0;
								state    <= hsm_pkg::S_ACK_W;
								if (first_byte) begin
									pointer <= shift;
								end else begin
									wr_en   <= 1'b1;
									wr_addr <= pointer;
									wr_data <= shift;
									pointer <= pointer + 8'h01;
								end
								first_byte <= 1'b0;
							end
						end
					end
					hsm_pkg::S_ACK_A: begin
						if (scl_fall) begin
							if (rw) begin
								shift    <= {rd_byte[6:0], 1'b0};
								SDA_OE_N <= rd_byte[7];
								pointer  <= pointer + 8'h01;
								state    <= hsm_pkg::S_RD;
							end else begin
								SDA_OE_N   <= 1'b1;
								first_byte <= 1'b1;
								state      <= hsm_pkg::S_WR;
							end
						end
					end
					hsm_pkg::S_ACK_W: begin
						if (scl_fall) begin
							SDA_OE_N <= 1'b1;
							state    <= hsm_pkg::S_WR;
						end
					end
					hsm_pkg::S_RD: begin
						if (scl_rise) begin
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall) begin
							if (bit_cnt == 4'h8) begin
								bit_cnt  <= 4'h0;
								SDA_OE_N <= 1'b1;
								state    <= hsm_pkg::S_ACK_R;
							end else begin
								SDA_OE_N <= shift[7];
								shift    <= {shift[6:0], 1'b0};
							end
						end
					end
					hsm_pkg::S_ACK_R: begin
						if (scl_rise && sda_sync[1]) begin
							state <= hsm_pkg::S_IDLE;
						end else if (scl_fall) begin
							shift    <= {rd_byte[6:0], 1'b0};
							SDA_OE_N <= rd_byte[7];
							pointer  <= pointer + 8'h01;
							state    <= hsm_pkg::S_RD;
						end
					end
					default: state <= hsm_pkg::S_IDLE;
				endcase
			end
		end
	end

endmodule : power_energy_monitor_datapath
`default_nettype wire

/* testbench/hsm_assertions.sv */
// Pin-level checks bound to the monitor datapath.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none

module hsm_checker #(
	parameter int CONV12_TICKS = 8,
	parameter int CONV16_TICKS = 16
) (
	// Clock and reset
	input wire logic       REF_CLK,
	input wire logic       RST,
	// Watched pins
	input wire logic       EXT_CLK_IN,
	input wire logic       CRYSTAL_DRIVE,
	input wire logic       SCL_IN,
	input wire logic       SDA_OE_N,
	input wire logic       ALERT_OE_N,
	input wire logic       CONV_START,
	input wire logic       CUR_SAMPLE,
	input wire logic       CONV_RES16,
	input wire logic [1:0] VOLT_RANGE,
	input wire logic       ADC_READY
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	logic ext_seen, armed;
	int   gap, lo_cnt, sgap;
	// External clock history, low-time count
	always_ff @(posedge REF_CLK) begin
		ext_seen <= !RST && (ext_seen || EXT_CLK_IN);
		lo_cnt   <= (RST || EXT_CLK_IN) ? 0 : lo_cnt + 1;
	end
	// Cycles since last start or sample; restart on mode change
	always_ff @(posedge REF_CLK) begin
		armed <= !(RST || $changed(CONV_RES16)) && (armed || CONV_START);
		gap   <= (RST || CONV_START) ? 1 : gap + 1;
		sgap  <= RST ? 0 : CUR_SAMPLE ? 1 : (sgap == 0) ? 0 : sgap + 1;
	end
	sequence s_quiet;
		##1 (!CUR_SAMPLE)[*8];
	endsequence
	sequence s_bus_idle_fall;
		SCL_IN[*8] ##0 $fell(ALERT_OE_N);
	endsequence
	property p_cur_pulse;
		CUR_SAMPLE |-> s_quiet;
	endproperty
	property p_cur_space;
		disable iff (RST || ext_seen) CUR_SAMPLE && sgap != 0 |-> sgap == 800;
	endproperty
	property p_conv_pulse;
		CONV_START |=> !CONV_START;
	endproperty
	property p_conv_space;
		disable iff (RST || ext_seen)
		CONV_START && armed && $stable(CONV_RES16)
			|-> gap == (CONV_RES16 ? CONV16_TICKS : CONV12_TICKS) * 200;
	endproperty
	property p_xtal_idle;
		lo_cnt > 262 |-> !CRYSTAL_DRIVE;
	endproperty
	property p_xtal_high;
		EXT_CLK_IN[*4] |-> !CRYSTAL_DRIVE;
	endproperty
	property p_res_ack;
		$changed(CONV_RES16) |-> !SDA_OE_N;
	endproperty
	property p_range_ack;
		$changed(VOLT_RANGE) |-> !SDA_OE_N;
	endproperty
	property p_alert_src;
		s_bus_idle_fall |-> $past(ADC_READY, 3) || $past(ADC_READY, 4);
	endproperty
	a_cur_pulse: assert property (p_cur_pulse) else $error("sample pulse too long");
	a_cur_space: assert property (p_cur_space) else $error("sample spacing wrong");
	a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse too long");
	a_conv_space: assert property (p_conv_space) else $error("conversion period wrong");
	a_xtal_idle: assert property (p_xtal_idle) else $error("drive with idle clock");
	a_xtal_high: assert property (p_xtal_high) else $error("drive not inverted");
	a_res_ack: assert property (p_res_ack) else $error("resolution moved off write");
	a_range_ack: assert property (p_range_ack) else $error("range moved off write");
	a_alert_src: assert property (p_alert_src) else $error("alert without result");
endmodule : hsm_checker

bind power_energy_monitor_datapath hsm_checker #(
	.CONV12_TICKS(CONV12_TICKS),
	.CONV16_TICKS(CONV16_TICKS)
) chk (.REF_CLK(REF_CLK), .RST(RST), .EXT_CLK_IN(EXT_CLK_IN), .CRYSTAL_DRIVE(CRYSTAL_DRIVE),
	.SCL_IN(SCL_IN), .SDA_OE_N(SDA_OE_N), .ALERT_OE_N(ALERT_OE_N), .CONV_START(CONV_START),
	.CUR_SAMPLE(CUR_SAMPLE), .CONV_RES16(CONV_RES16), .VOLT_RANGE(VOLT_RANGE),
	.ADC_READY(ADC_READY));
`default_nettype wire

/* testbench/i2c_host.sv */
// Two-wire host model: register writes and reads.
// Assumes a pulled-up data line, wire-anded with the device drive.
`timescale 1ns/1ps
`default_nettype none

module i2c_host #(
	parameter logic [6:0] DEV = 7'h50
) (
	// Clock and device drive
	input  wire logic clk,
	input  wire logic sda_oe_n,
	// Bus lines
	output logic      scl,
	output logic      sda
);
	int nacks = 0;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Ten clocks per phase; lines move on falling edges
	task automatic half;
		repeat (10) @(negedge clk);
	endtask : half
	task automatic bitx(input logic b, output logic r);
		sda = b;
		half();
		scl = 1'b1;
		half();
		r = sda & sda_oe_n;
		scl = 1'b0;
		@(negedge clk);
	endtask : bitx
	task automatic start;
		sda = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda = 1'b0;
		half();
		scl = 1'b0;
		@(negedge clk);
	endtask : start
	task automatic stop;
		sda = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda = 1'b1;
		half();
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(m, a);
	endtask : xfer
	// Host byte; a missing acknowledge is counted
	task automatic wb(input logic [7:0] d);
		logic [7:0] q;
		logic       a;
		xfer(d, 1'b1, q, a);
		nacks += int'(a);
	endtask : wb
	// High byte first, pointer auto-increments
	task automatic wr(input logic [7:0] ra, input logic [47:0] v, input int n);
		start();
		wb({DEV, 1'b0});
		wb(ra);
		for (int k = n - 1; k >= 0; k--) wb(v[8*k +: 8]);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] ra, input int n, output logic [47:0] v);
		logic [7:0] q;
		logic       a;
		v = '0;
		start();
		wb({DEV, 1'b0});
		wb(ra);
		start();
		wb({DEV, 1'b1});
		for (int k = 0; k < n; k++) begin
			xfer(8'hFF, k == n - 1, q, a);
			v = {v[39:0], q};
		end
		stop();
	endtask : rd
endmodule : i2c_host
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the monitor datapath.
// Assumes short conversion counts; inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        REF_CLK = 1'b0;
	logic        RST = 1'b1;
	logic        EXT_CLK_IN = 1'b0;
	logic        ADC_READY = 1'b0;
	logic [15:0] c = '0, vi = '0, vo = '0, g2 = '0, g3 = '0;
	logic        scl, sda, oe_n, alert_n, xtal, res16, cs;
	logic [1:0]  vr;
	logic [47:0] v;
	int          errors = 0;
	int          cmp_count = 0;
	int          n;
	always #10 REF_CLK = ~REF_CLK;
	i2c_host host (.clk(REF_CLK), .sda_oe_n(oe_n), .scl(scl), .sda(sda));
	power_energy_monitor_datapath #(.CONV12_TICKS(8), .CONV16_TICKS(16)) DUT (
		.REF_CLK(REF_CLK), .RST(RST), .EXT_CLK_IN(EXT_CLK_IN), .CRYSTAL_DRIVE(xtal),
		.SCL_IN(scl), .SDA_IN(sda & oe_n), .SDA_OUT(), .SDA_OE_N(oe_n), .ALERT_OUT(),
		.ALERT_OE_N(alert_n), .CONV_START(), .CUR_SAMPLE(cs), .CONV_RES16(res16),
		.VOLT_RANGE(vr), .ADC_READY(ADC_READY), .ADC_CUR_CODE(c), .ADC_VIN_CODE(vi),
		.ADC_VOUT_CODE(vo), .ADC_SECOND_GENERAL_INPUT_CODE(g2), .ADC_THIRD_GENERAL_INPUT_CODE(g3));
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdc(input string nm, input logic [7:0] ra, input int k, input logic [47:0] e);
		host.rd(ra, k, v);
		chk(nm, e, v);
	endtask : rdc
	// One result set, then settle
	task automatic conv(input logic [15:0] a = 16'h0ABC, b = 16'h0111, d = 16'h0800,
		e = 16'h0222, f = 16'h0123);
		@(negedge REF_CLK);
		{c, vi, vo, g2, g3} = {a, b, d, e, f};
		ADC_READY = 1'b1;
		@(negedge REF_CLK);
		ADC_READY = 1'b0;
		repeat (4) @(negedge REF_CLK);
	endtask : conv
	task automatic conclude;
		$display("Counts: %0d compared, %0d mismatched", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	// Watchdog, then the test sequence
	initial begin
		fork begin
			repeat (90000) @(posedge REF_CLK);
			errors++;
			conclude();
		end join_none
		repeat (6) @(negedge REF_CLK);
		RST = 1'b0;
		repeat (4) @(negedge REF_CLK);
		host.wr(8'h11, 48'h01, 1);
		chk("res16", 48'h1, {47'b0, res16});
		conv(16'h8000, 16'h4000, 16'h2000, 16'h1234, 16'h5678);
		rdc("power", 8'h40, 2, 48'h2000);
		rdc("volt", 8'h4C, 2, 48'h4000);
		rdc("gpio", 8'h52, 2, 48'h1234);
		repeat (7000) @(negedge REF_CLK);
		$display("Test 16-bit done");
		host.wr(8'h11, 48'h06, 1);
		host.wr(8'h0A, 48'hABAB, 2);
		host.wr(8'h03, 48'h20, 1);
		conv();
		rdc("cur", 8'h46, 2, 48'hABC0);
		rdc("power", 8'h40, 2, 48'h55E0);
		rdc("volt", 8'h4C, 2, 48'h8000);
		rdc("gpio", 8'h52, 2, 48'h1230);
		rdc("curmax", 8'h48, 2, 48'hABC0);
		rdc("curmin", 8'h4A, 2, 48'h8000);
		rdc("log", 8'h05, 1, 48'h30);
		chk("alert", 48'h0, {47'b0, alert_n});
		host.wr(8'h05, 48'h00, 1);
		chk("alert", 48'h1, {47'b0, alert_n});
		host.wr(8'h03, 48'h00, 1);
		$display("Test 12-bit done");
		rdc("energy", 8'h58, 6, 48'h75E000);
		rdc("count", 8'h5E, 4, 48'h2);
		host.wr(8'h10, 48'h80, 1);
		conv();
		rdc("charge", 8'h58, 6, 48'h768BC0);
		host.wr(8'h1D, 48'h01, 1);
		host.wr(8'h58, 48'hFFFFFFFFFFFF, 6);
		host.wr(8'h5E, 48'hFFFFFFFE, 4);
		conv();
		chk("alert", 48'h0, {47'b0, alert_n});
		rdc("count", 8'h5E, 4, 48'hFFFFFFFF);
		conv();
		rdc("wrap", 8'h58, 6, 48'h1577F);
		rdc("count", 8'h5E, 4, 48'h0);
		rdc("flags", 8'h1F, 1, 48'h3);
		host.wr(8'h1D, 48'h40, 1);
		host.wr(8'h1D, 48'h00, 1);
		rdc("flags", 8'h1F, 1, 48'h0);
		rdc("energy", 8'h58, 6, 48'h0);
		$display("Test meter done");
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h01, 48'(i), 1);
			chk("range", 48'(i), {46'b0, vr});
		end
		host.wr(8'h7F, 48'h55, 1);
		rdc("unmapped", 8'h7F, 1, 48'h0);
		$display("Test registers done");
		host.wr(8'h10, 48'h08, 1);
		// Roughly 4 MHz external clock, then grounded
		fork repeat (400) begin
			EXT_CLK_IN = 1'b1;
			repeat (6) @(negedge REF_CLK);
			EXT_CLK_IN = 1'b0;
			repeat (6) @(negedge REF_CLK);
		end join_none
		repeat (1500) @(negedge REF_CLK);
		while (cs !== 1'b1) @(negedge REF_CLK);
		n = 1;
		@(negedge REF_CLK);
		while (cs !== 1'b1) begin
			n++;
			@(negedge REF_CLK);
		end
		chk("sample gap", 48'd768, 48'(n));
		repeat (3600) @(negedge REF_CLK);
		chk("xtal", 48'h0, {47'b0, xtal});
		chk("nacks", 48'h0, 48'(host.nacks));
		$display("Test timebase done");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
